// ===== design/prot_stage_common.sv
// protection stage common logic: group select, stage status, timing, force
// assumes stage settings arrive for the active group from a settings store
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "prot_map.svh"

module prot_stage_common #(
	parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
	input  wire logic                              clk_sys,
	input  wire logic                              sys_rst,
	input  wire logic                              ce,
	input  wire prot_pkg::reg_req_t                req,
	output logic [31:0]                            rdata_q,
	input  wire logic [`DISCRETE_INPUTS-1:0]       discrete_input,
	input  wire logic                              panel_button,
	input  wire logic [15:0]                       feeder_rated_current,
	input  wire logic [15:0]                       motor_rated_current,
	input  wire logic [15:0]                       meas [`STAGES],
	input  wire prot_pkg::stage_cfg_t              cfg [`STAGES],
	input  wire logic [`STAGES-1:0]                block_in,
	output logic [1:0]                             active_group_select_q,
	output logic                                   force_flag_q,
	output logic [`STAGES-1:0]                     stage_enabled_q,
	output prot_pkg::stage_state_t                 status_q [`STAGES],
	output logic                                   start_q [`STAGES],
	output logic                                   trip_q [`STAGES],
	output logic [31:0]                            relay_force_q
);
	import prot_pkg::*;

	localparam int FORCE_WIN = `FORCE_WINDOW_MS;
	localparam int TIMEOUT   = `FORCE_TIMEOUT_MS;
	// longest reset delay that stays strictly below the limit
	localparam logic [15:0] RESET_MAX = 16'(`RESET_LIMIT_MS - 1);

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	localparam int NSYNC = `DISCRETE_INPUTS + 1;
	logic [NSYNC-1:0] s1_q, s2_q, s3_q, stab_q, stab_d;
	logic [NSYNC-1:0] pin_raw;
	logic             btn_prev_q, btn_prev_d, btn_pulse;
	logic [`DISCRETE_INPUTS-1:0] di_stable;

	assign pin_raw   = {panel_button, discrete_input};
	assign di_stable = stab_q[`DISCRETE_INPUTS-1:0];

	always_comb begin
		// a change counts only once stages two and three agree
		stab_d = stab_q;
		for (int i = 0; i < NSYNC; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				stab_d[i] = s3_q[i];
			end
		end
		btn_prev_d = stab_q[NSYNC-1];
		btn_pulse  = stab_q[NSYNC-1] & ~btn_prev_q;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_q       <= '0;
			s2_q       <= '0;
			s3_q       <= '0;
			stab_q     <= '0;
			btn_prev_q <= 1'b0;
		end else if (ce) begin
			s1_q       <= pin_raw;
			s2_q       <= s1_q;
			s3_q       <= s2_q;
			stab_q     <= stab_d;
			btn_prev_q <= btn_prev_d;
		end
	end

	// ---------------------------------------------------------------
	// millisecond tick and force flag
	// ---------------------------------------------------------------
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic        tick;
	logic [18:0] idle_q, idle_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic        wr_ctrl;

	assign tick    = (tick_cnt_q == 32'(TICK_CYCLES - 1));
	assign wr_ctrl = req.we && (req.addr == `REG_CTRL);

	always_comb begin
		tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
		idle_d     = idle_q;
		ctrl_d     = ctrl_q;
		if (btn_pulse || (wr_ctrl && req.wdata[`CTRL_FORCE_BIT])) begin
			idle_d = 19'h00000;
		end else if (tick && idle_q != 19'(TIMEOUT)) begin
			idle_d = idle_q + 19'h00001;
		end
		// auto clear; a software set in the same cycle wins
		if (idle_q == 19'(TIMEOUT)) begin
			ctrl_d[`CTRL_FORCE_BIT] = 1'b0;
		end
		if (wr_ctrl) begin
			ctrl_d = req.wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tick_cnt_q <= 32'h0000_0000;
			idle_q     <= 19'h00000;
			ctrl_q     <= `CTRL_RESET;
		end else if (ce) begin
			tick_cnt_q <= tick_cnt_d;
			idle_q     <= idle_d;
			ctrl_q     <= ctrl_d;
		end
	end

	logic motor_mode, force_on, prio_desc;
	logic [1:0] default_group;
	assign motor_mode    = ctrl_q[`CTRL_MOTOR_BIT];
	assign force_on      = ctrl_q[`CTRL_FORCE_BIT];
	assign prio_desc     = ctrl_q[`CTRL_DESC_BIT];
	assign default_group = ctrl_q[`CTRL_DEFGRP_LSB +: 2];

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	logic [31:0] en_q, motor_only_q, cur_mask_q, unblk_q, latch_en_q, grp_sel_q, virt_q;
	logic [31:0] en_d, motor_only_d, cur_mask_d, unblk_d, latch_en_d, grp_sel_d, virt_d;
	logic [31:0] relay_force_d;
	logic        fcmd_go, latch_clr;
	logic [4:0]  fcmd_stage;
	logic        fcmd_trip;

	always_comb begin
		en_d          = en_q;
		motor_only_d  = motor_only_q;
		cur_mask_d    = cur_mask_q;
		unblk_d       = unblk_q;
		latch_en_d    = latch_en_q;
		grp_sel_d     = grp_sel_q;
		virt_d        = virt_q;
		relay_force_d = force_on ? relay_force_q : 32'h0000_0000;
		if (req.we) begin
			unique case (req.addr)
				`REG_STAGE_EN:     en_d         = req.wdata;
				`REG_MOTOR_ONLY:   motor_only_d = req.wdata;
				`REG_CURRENT_MASK: cur_mask_d   = req.wdata;
				`REG_UNBLOCKABLE:  unblk_d      = req.wdata;
				`REG_LATCH_EN:     latch_en_d   = req.wdata;
				`REG_GROUP_SEL:    grp_sel_d    = req.wdata;
				`REG_VIRT_IN:      virt_d       = req.wdata;
				// relay forcing only while the flag is set
				`REG_RELAY_FORCE:  relay_force_d = force_on ? req.wdata : 32'h0000_0000;
				default:           ;
			endcase
		end
	end

	assign fcmd_go    = req.we && (req.addr == `REG_FORCE_CMD) && req.wdata[`FCMD_GO_BIT];
	assign fcmd_stage = req.wdata[4:0];
	assign fcmd_trip  = req.wdata[`FCMD_KIND_BIT];
	assign latch_clr  = req.we && (req.addr == `REG_LATCH_CLR);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_q          <= 32'h0000_0000;
			motor_only_q  <= 32'h0000_0000;
			cur_mask_q    <= 32'h0000_0000;
			unblk_q       <= 32'h0000_0000;
			latch_en_q    <= 32'h0000_0000;
			grp_sel_q     <= 32'h0000_0000;
			virt_q        <= 32'h0000_0000;
			relay_force_q <= 32'h0000_0000;
		end else if (ce) begin
			en_q          <= en_d;
			motor_only_q  <= motor_only_d;
			cur_mask_q    <= cur_mask_d;
			unblk_q       <= unblk_d;
			latch_en_q    <= latch_en_d;
			grp_sel_q     <= grp_sel_d;
			virt_q        <= virt_d;
			relay_force_q <= relay_force_d;
		end
	end

	// ---------------------------------------------------------------
	// setting group selection
	// ---------------------------------------------------------------
	logic [31:0]        grp_src;
	logic [`GROUPS-1:0] grp_act;
	logic [1:0]         group_d;

	// index 0 means no input; 1..16 discrete, 17..24 virtual
	assign grp_src = {7'h00, virt_q[`VIRTUAL_INPUTS-1:0], di_stable, 1'b0};

	generate
		for (genvar g = 0; g < `GROUPS; g++) begin : g_grp
			assign grp_act[g] = grp_src[grp_sel_q[g*`GRPSEL_STRIDE +: 5]];
		end
	endgenerate

	always_comb begin
		group_d = default_group;
		// scan so the winning group is assigned last
		for (int g = `GROUPS - 1; g >= 0; g--) begin
			if (!prio_desc && grp_act[g]) begin
				group_d = 2'(g);
			end
		end
		for (int g = 0; g < `GROUPS; g++) begin
			if (prio_desc && grp_act[g]) begin
				group_d = 2'(g);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			active_group_select_q <= 2'h0;
		end else if (ce) begin
			active_group_select_q <= group_d;
		end
	end

	// ---------------------------------------------------------------
	// enable cap and per-stage logic
	// ---------------------------------------------------------------
	logic [5:0]         en_cnt [`STAGES+1];
	logic [`STAGES-1:0] en_eff;
	assign en_cnt[0] = 6'h00;

	generate
		for (genvar i = 0; i < `STAGES; i++) begin : g_stage
			logic avail;
			assign avail = !motor_only_q[i] || motor_mode;
			// later stages lose their enable past the cap
			assign en_eff[i]   = en_q[i] && avail && (en_cnt[i] < 6'(`MAX_ENABLED));
			assign en_cnt[i+1] = en_cnt[i] + 6'(en_eff[i]);

			// current reference by mode; motor-only always motor
			logic [15:0] ref_cur, thr;
			logic [31:0] prod;
			logic [16:0] lo_lvl, hi_lvl;
			assign ref_cur = (motor_mode || motor_only_q[i]) ?
				motor_rated_current : feeder_rated_current;
			assign prod = cfg[i].pickup * ref_cur;
			// pickup in 1/256 of the reference; saturates at full scale
			assign thr  = cur_mask_q[i] ?
				((prod[31:24] != 8'h00) ? 16'hFFFF : prod[23:8]) : cfg[i].pickup;
			assign lo_lvl = {1'b0, thr} - {1'b0, cfg[i].hyst};
			assign hi_lvl = {1'b0, thr} + {1'b0, cfg[i].hyst};

			stage_state_t st_q, st_d, rep_d;
			logic         flt_q, flt_d, blk;
			logic [15:0]  tmr_q, tmr_d, rst_q, rst_d, rst_len;
			logic [9:0]   fcnt_q, fcnt_d;
			logic         fkind_q, fkind_d;
			logic         shold_q, shold_d, thold_q, thold_d;
			logic         start_d, trip_d;

			assign rst_len = (cfg[i].reset_ms > RESET_MAX) ? RESET_MAX : cfg[i].reset_ms;
			assign blk = block_in[i] && !unblk_q[i];

			always_comb begin
				// dead band on both comparator kinds
				flt_d = flt_q;
				if (!cfg[i].under) begin
					if (!flt_q && {1'b0, meas[i]} > {1'b0, thr}) begin
						flt_d = 1'b1;
					end else if (flt_q && (lo_lvl[16] || {1'b0, meas[i]} < lo_lvl)) begin
						flt_d = lo_lvl[16] ? 1'b1 : 1'b0;
					end
				end else begin
					if (!flt_q && meas[i] < thr) begin
						flt_d = 1'b1;
					end else if (flt_q && {1'b0, meas[i]} > hi_lvl) begin
						flt_d = 1'b0;
					end
				end

				st_d    = st_q;
				tmr_d   = tmr_q;
				rst_d   = rst_q;
				shold_d = shold_q;
				thold_d = thold_q;
				unique case (st_q)
					ST_IDLE: begin
						tmr_d = 16'h0000;
						if (flt_q && blk) begin
							st_d = ST_BLOCKED;
						end else if (flt_q) begin
							st_d = ST_START;
						end
					end
					ST_BLOCKED: begin
						if (!flt_q) begin
							st_d  = ST_IDLE;
							tmr_d = 16'h0000;
						end else if (!blk) begin
							st_d = ST_START;
						end
					end
					ST_START: begin
						// clearing abandons the delay in one cycle
						if (!flt_q) begin
							st_d    = ST_IDLE;
							tmr_d   = 16'h0000;
							shold_d = 1'b1;
							rst_d   = rst_len;
						end else if (blk) begin
							st_d = ST_BLOCKED;
						end else if (tmr_q >= cfg[i].delay_ms) begin
							st_d = ST_TRIP;
						end else if (tick) begin
							tmr_d = tmr_q + 16'h0001;
						end
					end
					ST_TRIP: begin
						// held while fault present, blocking ignored
						if (!flt_q) begin
							st_d    = ST_IDLE;
							tmr_d   = 16'h0000;
							shold_d = 1'b1;
							thold_d = 1'b1;
							rst_d   = rst_len;
						end
					end
				endcase
				if (!en_eff[i]) begin
					st_d    = ST_IDLE;
					tmr_d   = 16'h0000;
					shold_d = 1'b0;
					thold_d = 1'b0;
				end

				// release after reset delay unless latched
				if ((shold_q || thold_q) && st_d == ST_IDLE) begin
					if (rst_q != 16'h0000) begin
						if (tick) begin
							rst_d = rst_q - 16'h0001;
						end
					end else if (!latch_en_q[i] || latch_clr) begin
						shold_d = 1'b0;
						thold_d = 1'b0;
					end
				end
				if (st_d != ST_IDLE) begin
					shold_d = 1'b0;
					thold_d = 1'b0;
				end

				fcnt_d  = fcnt_q;
				fkind_d = fkind_q;
				if (!force_on) begin
					fcnt_d = 10'h000;
				end else if (fcmd_go && fcmd_stage == 5'(i)) begin
					fcnt_d  = 10'(FORCE_WIN);
					fkind_d = fcmd_trip;
				end else if (tick && fcnt_q != 10'h000) begin
					fcnt_d = fcnt_q - 10'h001;
				end

				rep_d   = st_d;
				start_d = (st_d == ST_START) || (st_d == ST_TRIP) || shold_d;
				trip_d  = (st_d == ST_TRIP) || thold_d;
				if (fcnt_d != 10'h000) begin
					rep_d   = fkind_d ? ST_TRIP : ST_START;
					start_d = 1'b1;
					trip_d  = fkind_d;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					st_q        <= ST_IDLE;
					flt_q       <= 1'b0;
					tmr_q       <= 16'h0000;
					rst_q       <= 16'h0000;
					fcnt_q      <= 10'h000;
					fkind_q     <= 1'b0;
					shold_q     <= 1'b0;
					thold_q     <= 1'b0;
					status_q[i] <= ST_IDLE;
					start_q[i]  <= 1'b0;
					trip_q[i]   <= 1'b0;
				end else if (ce) begin
					st_q        <= st_d;
					flt_q       <= flt_d;
					tmr_q       <= tmr_d;
					rst_q       <= rst_d;
					fcnt_q      <= fcnt_d;
					fkind_q     <= fkind_d;
					shold_q     <= shold_d;
					thold_q     <= thold_d;
					status_q[i] <= rep_d;
					start_q[i]  <= start_d;
					trip_q[i]   <= trip_d;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	logic [31:0] rdata_d, st_lo, st_hi, so_v, to_v;

	always_comb begin
		st_lo = 32'h0000_0000;
		st_hi = 32'h0000_0000;
		so_v  = 32'h0000_0000;
		to_v  = 32'h0000_0000;
		for (int i = 0; i < `STAGES; i++) begin
			if (i < 16) begin
				st_lo[2*i +: 2] = status_q[i];
			end else begin
				st_hi[2*(i-16) +: 2] = status_q[i];
			end
			so_v[i] = start_q[i];
			to_v[i] = trip_q[i];
		end
		// data stand one cycle only; unmapped reads return zero
		rdata_d = 32'h0000_0000;
		if (req.re) begin
			unique case (req.addr)
				`REG_CTRL:         rdata_d = ctrl_q;
				`REG_STAGE_EN:     rdata_d = en_q;
				`REG_MOTOR_ONLY:   rdata_d = motor_only_q;
				`REG_CURRENT_MASK: rdata_d = cur_mask_q;
				`REG_UNBLOCKABLE:  rdata_d = unblk_q;
				`REG_LATCH_EN:     rdata_d = latch_en_q;
				`REG_GROUP_SEL:    rdata_d = grp_sel_q;
				`REG_VIRT_IN:      rdata_d = virt_q;
				`REG_STATUS:       rdata_d = {24'h000000, en_cnt[`STAGES], active_group_select_q};
				`REG_STATE_LO:     rdata_d = st_lo;
				`REG_STATE_HI:     rdata_d = st_hi;
				`REG_START_OUT:    rdata_d = so_v;
				`REG_TRIP_OUT:     rdata_d = to_v;
				`REG_RELAY_FORCE:  rdata_d = relay_force_q;
				default:           rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdata_q         <= 32'h0000_0000;
			force_flag_q    <= 1'b0;
			stage_enabled_q <= '0;
		end else if (ce) begin
			rdata_q         <= rdata_d;
			force_flag_q    <= ctrl_d[`CTRL_FORCE_BIT];
			stage_enabled_q <= en_eff;
		end
	end
endmodule

// ===== common/prot_map.svh
// register offsets, field positions, reset values and timing counts
// assumes a 200 MHz system clock and 32-bit register words
`ifndef PROT_MAP_SVH
`define PROT_MAP_SVH

`define STAGES             32
`define MAX_ENABLED        30
`define GROUPS             4
`define DISCRETE_INPUTS    16
`define VIRTUAL_INPUTS     8

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define REG_CTRL           8'h00
`define REG_STAGE_EN       8'h04
`define REG_MOTOR_ONLY     8'h08
`define REG_CURRENT_MASK   8'h0C
`define REG_UNBLOCKABLE    8'h10
`define REG_LATCH_EN       8'h14
`define REG_GROUP_SEL      8'h18
`define REG_VIRT_IN        8'h1C
`define REG_FORCE_CMD      8'h20
`define REG_LATCH_CLR      8'h24
`define REG_STATUS         8'h28
`define REG_STATE_LO       8'h2C
`define REG_STATE_HI       8'h30
`define REG_START_OUT      8'h34
`define REG_TRIP_OUT       8'h38
`define REG_RELAY_FORCE    8'h3C

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CTRL_MOTOR_BIT     0
`define CTRL_FORCE_BIT     1
`define CTRL_DESC_BIT      2
`define CTRL_DEFGRP_LSB    3
`define CTRL_RESET         32'h0000_0000
`define GRPSEL_STRIDE      8
`define FCMD_KIND_BIT      5
`define FCMD_GO_BIT        6

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      5
`define TICK_NS            1000000
`define FORCE_WINDOW_MS    500
`define FORCE_TIMEOUT_MIN  5
`define FORCE_TIMEOUT_MS   (`FORCE_TIMEOUT_MIN * 60 * 1000)
`define RESET_LIMIT_MS     95
`define RETARD_LIMIT_MS    50

`endif

// ===== common/prot_pkg.sv
// types shared by the protection stage common logic
// assumes prot_map.svh supplies the numeric constants
`include "prot_map.svh"

package prot_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BLOCKED,
		ST_START,
		ST_TRIP
	} stage_state_t;

	// settings of one stage for the currently active group
	typedef struct packed {
		logic [15:0] delay_ms;
		logic [15:0] reset_ms;
		logic [15:0] pickup;
		logic [15:0] hyst;
		logic        under;
	} stage_cfg_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} reg_req_t;
endpackage

// ===== dv/stage_props.sv
// concurrent checks on the stage common logic ports
// assumes binding to prot_stage_common, stage 0 never forced
`timescale 1ns/1ps
`include "prot_map.svh"

module stage_props
	import prot_pkg::*;
(
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire prot_pkg::reg_req_t     req,
	input wire logic [31:0]            rdata_q,
	input wire logic [15:0]            meas [`STAGES],
	input wire prot_pkg::stage_cfg_t   cfg [`STAGES],
	input wire logic [`STAGES-1:0]     block_in,
	input wire logic                   force_flag_q,
	input wire logic [`STAGES-1:0]     stage_enabled_q,
	input wire prot_pkg::stage_state_t status_q [`STAGES],
	input wire logic                   start_q [`STAGES],
	input wire logic                   trip_q [`STAGES],
	input wire logic [31:0]            relay_force_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// ----
	// output relations
	// ----
	relay_off_a: assert property (!force_flag_q && !$past(force_flag_q)
		|-> relay_force_q == 32'h0) else $error("relay force pattern while force off");
	read_idle_a: assert property (!$past(req.re) |-> rdata_q == 32'h0)
		else $error("read data outside read answer cycle");
	start_out_a: assert property (status_q[0] == ST_START |-> start_q[0])
		else $error("start status without start output");
	trip_out_a: assert property (status_q[0] == ST_TRIP |-> trip_q[0] && start_q[0])
		else $error("trip status without trip output");
	trip_entry_a: assert property (status_q[0] == ST_TRIP && $past(status_q[0]) != ST_TRIP
		|-> $past(status_q[0]) == ST_START) else $error("trip not entered from start");
	block_hold_a: assert property (status_q[0] == ST_IDLE && block_in[0] && $past(block_in[0])
		|=> status_q[0] != ST_START) else $error("blocked stage picked up");
	trip_block_a: assert property (status_q[0] == ST_TRIP && block_in[0]
		&& meas[0] > cfg[0].pickup && $past(meas[0]) > cfg[0].pickup
		|=> status_q[0] == ST_TRIP) else $error("block left trip status");
	enable_cap_a: assert property ($countones(stage_enabled_q) <= 30)
		else $error("more than thirty stages enabled");
	start_fall_a: assert property ($fell(start_q[0]) |-> status_q[0] != ST_START)
		else $error("start released while timing");
endmodule

bind prot_stage_common stage_props i_props (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rdata_q(rdata_q), .meas(meas),
	.cfg(cfg), .block_in(block_in), .force_flag_q(force_flag_q),
	.stage_enabled_q(stage_enabled_q), .status_q(status_q), .start_q(start_q),
	.trip_q(trip_q), .relay_force_q(relay_force_q)
);

// ===== dv/meas_source.sv
// comparator feed, stage settings and block matrix lines
// assumes the bench raises fault, band and blk per stage
`timescale 1ns/1ps
`include "prot_map.svh"

module meas_source
	import prot_pkg::*;
(
	input wire logic                clk_sys,
	input wire logic [`STAGES-1:0]  fault,
	input wire logic [`STAGES-1:0]  band,
	input wire logic [`STAGES-1:0]  blk,
	output logic [15:0]             meas [`STAGES],
	output prot_pkg::stage_cfg_t    cfg [`STAGES],
	output logic [`STAGES-1:0]      block_in
);
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < `STAGES; i++) begin
			meas[i] <= band[i] ? 16'h005F : (fault[i] ? 16'h00C8 : 16'h0032);
			cfg[i] <= '{16'h000A, 16'h0002, 16'h0064, 16'h000A, 1'b0};
		end
		block_in <= blk;
	end
endmodule

// ===== dv/prot_stage_common_bench.sv
// self-checking bench for the stage common logic
// assumes a 4-cycle tick so that delays stay short
`timescale 1ns/1ps
`include "prot_map.svh"

module prot_stage_common_bench;
	import prot_pkg::*;
	logic                   clk_sys = 1'b0;
	logic                   sys_rst = 1'b1;
	reg_req_t               req = '0;
	logic [31:0]            rdata_q;
	logic [15:0]            discrete_input = 16'h0;
	logic [31:0]            fault = '0;
	logic [31:0]            band = '0;
	logic [31:0]            blk = '0;
	logic [15:0]            meas [`STAGES];
	stage_cfg_t             cfg [`STAGES];
	logic [31:0]            block_in;
	logic [1:0]             active_group_select_q;
	logic                   force_flag_q;
	logic [31:0]            stage_enabled_q;
	stage_state_t           status_q [`STAGES];
	logic                   start_q [`STAGES];
	logic                   trip_q [`STAGES];
	logic [31:0]            relay_force_q;
	int                     failures = 0;
	int                     n_compared = 0;

	prot_stage_common #(.TICK_CYCLES(4)) i_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .req(req), .rdata_q(rdata_q),
		.discrete_input(discrete_input), .panel_button(1'b0),
		.feeder_rated_current(16'h0100), .motor_rated_current(16'h0200),
		.meas(meas), .cfg(cfg), .block_in(block_in),
		.active_group_select_q(active_group_select_q), .force_flag_q(force_flag_q),
		.stage_enabled_q(stage_enabled_q), .status_q(status_q), .start_q(start_q),
		.trip_q(trip_q), .relay_force_q(relay_force_q)
	);
	meas_source i_src (.clk_sys(clk_sys), .fault(fault), .band(band), .blk(blk),
		.meas(meas), .cfg(cfg), .block_in(block_in));

	// ----
	// shared tasks
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic drive(input logic [31:0] f, input logic [31:0] b, input logic [31:0] k,
		input logic [15:0] d);
		@(posedge clk_sys);
		fault <= f;
		band <= b;
		blk <= k;
		discrete_input <= d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req.addr <= a;
		req.wdata <= d;
		req.we <= 1'b1;
		@(posedge clk_sys);
		req.we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		req.addr <= a;
		req.re <= 1'b1;
		@(posedge clk_sys);
		req.re <= 1'b0;
		#1 check(rdata_q, exp);
	endtask
	task automatic wait_st(input int s, input stage_state_t v, input int n);
		for (int i = 0; i < n && status_q[s] !== v; i++) tick(1);
		check(32'(status_q[s]), 32'(v));
	endtask
	task automatic wrap_up();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_enable();
		rd(`REG_CTRL, 32'h0);
		rd(8'hFC, 32'h0);
		wr(`REG_STAGE_EN, 32'hFFFF_FFFF);
		wr(`REG_MOTOR_ONLY, 32'h1);
		tick(4);
		check(stage_enabled_q, 32'h7FFF_FFFE);
		rd(`REG_STATUS, 32'h78);
		wr(`REG_CTRL, 32'h1);
		tick(4);
		check(stage_enabled_q, 32'h3FFF_FFFF);
		wr(`REG_CTRL, 32'h0);
		wr(`REG_MOTOR_ONLY, 32'h0);
		wr(`REG_STAGE_EN, 32'h5);
	endtask
	task automatic t_group();
		wr(`REG_GROUP_SEL, 32'h0403_0201);
		wr(`REG_CTRL, 32'h10);
		tick(8);
		check(active_group_select_q, 2'h2);
		drive(0, 0, 0, 16'h0006);
		tick(8);
		check(active_group_select_q, 2'h1);
		wr(`REG_CTRL, 32'h14);
		tick(4);
		check(active_group_select_q, 2'h2);
		drive(0, 0, 0, 16'h0008);
		tick(8);
		check(active_group_select_q, 2'h3);
		drive(0, 0, 0, 16'h0000);
		wr(`REG_GROUP_SEL, 32'h11);
		wr(`REG_VIRT_IN, 32'h1);
		tick(8);
		check(active_group_select_q, 2'h0);
		wr(`REG_VIRT_IN, 32'h0);
		tick(8);
		check(active_group_select_q, 2'h2);
		wr(`REG_CTRL, 32'h0);
	endtask
	task automatic t_trip();
		int n;
		drive(1, 0, 0, 0);
		wait_st(0, ST_START, 10);
		check(32'(start_q[0]), 1);
		drive(0, 0, 0, 0);
		wait_st(0, ST_IDLE, 4);
		tick(20);
		drive(1, 0, 0, 0);
		wait_st(0, ST_TRIP, 60);
		check(32'(trip_q[0]), 1);
		drive(1, 0, 1, 0);
		tick(10);
		check(32'(status_q[0]), 32'(ST_TRIP));
		drive(0, 0, 0, 0);
		wait_st(0, ST_IDLE, 4);
		check(32'(trip_q[0]), 1);
		for (n = 0; n < 30 && trip_q[0] !== 1'b0; n++) tick(1);
		check(32'(trip_q[0]), 0);
		check(32'(n >= 2 && n < 16), 1);
		tick(10);
	endtask
	task automatic t_block();
		drive(1, 0, 1, 0);
		wait_st(0, ST_BLOCKED, 10);
		check(32'(start_q[0]), 0);
		drive(1, 0, 0, 0);
		wait_st(0, ST_START, 6);
		tick(20);
		drive(1, 0, 1, 0);
		wait_st(0, ST_BLOCKED, 4);
		tick(80);
		check(32'(trip_q[0]), 0);
		// remaining delay is well under a full restart of 40 cycles
		drive(1, 0, 0, 0);
		wait_st(0, ST_TRIP, 30);
		drive(0, 0, 0, 0);
		wait_st(0, ST_IDLE, 4);
		tick(20);
	endtask
	task automatic t_hyst();
		drive(0, 1, 0, 0);
		tick(8);
		check(32'(status_q[0]), 32'(ST_IDLE));
		drive(1, 0, 0, 0);
		wait_st(0, ST_START, 6);
		drive(0, 1, 0, 0);
		tick(8);
		check(32'(status_q[0]), 32'(ST_START));
		drive(0, 0, 0, 0);
		wait_st(0, ST_IDLE, 4);
		tick(20);
	endtask
	// scaled pickup doubles in motor mode; stage 2 marked unblockable
	task automatic t_mode();
		wr(`REG_CURRENT_MASK, 32'h1);
		wr(`REG_CTRL, 32'h1);
		drive(1, 0, 0, 0);
		tick(8);
		check(32'(status_q[0]), 32'(ST_IDLE));
		wr(`REG_CTRL, 32'h0);
		wait_st(0, ST_START, 6);
		wr(`REG_UNBLOCKABLE, 32'h4);
		drive(32'h4, 0, 32'h4, 0);
		wait_st(2, ST_START, 6);
		drive(0, 0, 0, 0);
		wait_st(2, ST_IDLE, 4);
		wr(`REG_UNBLOCKABLE, 32'h0);
		wr(`REG_CURRENT_MASK, 32'h0);
		tick(20);
	endtask
	task automatic t_force();
		wr(`REG_RELAY_FORCE, 32'h5A);
		tick(2);
		check(relay_force_q, 32'h0);
		wr(`REG_CTRL, 32'h2);
		wr(`REG_RELAY_FORCE, 32'h5A);
		rd(`REG_RELAY_FORCE, 32'h5A);
		wr(`REG_FORCE_CMD, 32'h62);
		wait_st(2, ST_TRIP, 5);
		check(32'(trip_q[2]), 1);
		tick(1900);
		check(32'(status_q[2]), 32'(ST_TRIP));
		wait_st(2, ST_IDLE, 200);
		wr(`REG_FORCE_CMD, 32'h42);
		wait_st(2, ST_START, 5);
		check(32'(trip_q[2]), 0);
		wr(`REG_CTRL, 32'h0);
		wait_st(2, ST_IDLE, 5);
		check(relay_force_q, 32'h0);
	endtask

	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		tick(2);
		t_enable();
		t_group();
		t_trip();
		t_block();
		t_hyst();
		t_mode();
		t_force();
		wrap_up();
	end
	// whole run is near 2500 cycles
	initial begin
		#100000;
		failures++;
		wrap_up();
	end
endmodule
